//--- hw/bia_pkg.sv
package bia_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus geometry: printed offsets are word indices, byte address = 4 * index
  localparam int          BIA_ADDR_W  = 18;
  localparam int          BIA_IDX_W   = 16;
  localparam int          BIA_DATA_W  = 32;
  localparam int          BIA_REG_W   = 8;
  localparam logic [1:0]  BIA_ALIGNED = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices inside one channel page
  localparam logic [11:0] BIA_IDX_STATUS = 12'hB00;
  localparam logic [11:0] BIA_IDX_ENABLE = 12'hB01;
  localparam logic [11:0] BIA_IDX_FRAMER = 12'hB04;
  localparam logic [11:0] BIA_IDX_ALARM0 = 12'hB02;
  localparam logic [11:0] BIA_IDX_ALARM1 = 12'hB0E;
  localparam logic [11:0] BIA_IDX_ALARM2 = 12'hB40;
  localparam logic [11:0] BIA_IDX_SLIP   = 12'hB08;
  localparam logic [11:0] BIA_IDX_HDLC0  = 12'hB06;
  localparam logic [11:0] BIA_IDX_HDLC1  = 12'hB16;
  localparam logic [11:0] BIA_IDX_HDLC2  = 12'hB26;
  localparam logic [11:0] BIA_IDX_LOOP   = 12'hB0A;

  ////////////////////////////////////////////////////////////////////////////
  // Status and enable bit positions
  localparam int BIA_BIT_FRAMER = 0;
  localparam int BIA_BIT_ALARM  = 1;
  localparam int BIA_BIT_SLIP   = 2;
  localparam int BIA_BIT_HDLC   = 3;
  localparam int BIA_BIT_SEC    = 4;
  localparam int BIA_BIT_CLK    = 5;
  localparam int BIA_BIT_LOOP   = 6;

  localparam logic [7:0] BIA_ENABLE_RST  = 8'h00;
  localparam logic [7:0] BIA_ENABLE_MASK = 8'h7F;

  ////////////////////////////////////////////////////////////////////////////
  // Flag bank layout: nine source flags, then two event flags
  localparam int BIA_NSRC   = 9;
  localparam int BIA_NFLAG  = 11;
  localparam int BIA_F_SEC  = 9;
  localparam int BIA_F_CLK  = 10;

  // One bit per source status register, framer in bit 0
  typedef struct packed {
    logic       loop;
    logic [2:0] hdlc;
    logic       slip;
    logic [2:0] alarm;
    logic       framer;
  } bia_src_t;

  // One-cycle event strobes
  typedef struct packed {
    logic clk_loss;
    logic second_tick;
  } bia_evt_t;

endpackage

//--- hw/bia_flags.sv
`timescale 1ns/1ps
// Sticky flags: a set in the same cycle as a clear wins
module bia_flags #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Flag control
  input  wire logic [WIDTH-1:0] set,
  input  wire logic [WIDTH-1:0] clr,
  output logic      [WIDTH-1:0] flags
);

  logic [WIDTH-1:0] next_flags;

  assign next_flags = (flags & ~clr) | set;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= '0;
    end else begin
      flags <= next_flags;
    end
  end

endmodule // bia_flags

//--- hw/bia_top.sv
// Behaviour
// - Status bit 2 is high while the slip buffer block has a pending request, else low.
// - The slip bit returns to 0 once the host reads the slip source status register.
// - Status bit 1 is high while the alarm and error block has a pending request, else low.
// - The alarm bit clears once the host reads the alarm source register that raised it.
// - Status bit 0 is high while the framer block has a pending request, else low.
// - The framer bit returns to 0 once the host reads the framer source status register.
// - Enable bit 6 gates the loop code block: 0 suppresses it, 1 admits it.
// - The interrupt is raised for a source only when its block and source enables are set.
// - Enable bit 5 is the source enable of the recovered clock loss interrupt.
// - Enable bit 4 is the source enable of the one second interrupt.
// - Enable bit 3 gates the link controller block: 0 suppresses it, 1 admits it.
// - Status bit 6 follows the loop code block request and clears on its source read.
// - Status bit 5 records a clock loss since the last status read and clears on it.
// - Status bit 4 records a one second tick since the last status read and clears on it.
// - Status bit 3 follows the link controller request and clears on its source read.
`timescale 1ns/1ps
module bia_top #(
  parameter logic [3:0] CHANNEL = 4'h0
) (
  // Clock and reset
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  // APB slave
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [bia_pkg::BIA_ADDR_W-1:0] paddr,
  input  wire logic [bia_pkg::BIA_DATA_W-1:0] pwdata,
  input  wire logic [3:0]                     pstrb,
  output logic      [bia_pkg::BIA_DATA_W-1:0] prdata,
  output logic                                pready,
  output logic                                pslverr,
  // Block requests
  input  wire bia_pkg::bia_src_t              src_req,
  input  wire bia_pkg::bia_src_t              src_enable,
  input  wire bia_pkg::bia_evt_t              evt_pulse,
  // Interrupt
  output logic                                irq
);
  import bia_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  function automatic logic idx_hit(
    input logic [BIA_IDX_W-1:0] idx,
    input logic [11:0]          lo
  );
    return idx == {CHANNEL, lo};
  endfunction

  logic [BIA_IDX_W-1:0] idx;
  logic                 aligned;
  logic                 hit_status;
  logic                 hit_enable;
  logic [BIA_NSRC-1:0]  src_hit;
  logic                 mapped;

  assign idx        = paddr[BIA_ADDR_W-1:2];
  assign aligned    = paddr[1:0] == BIA_ALIGNED;
  assign hit_status = aligned & idx_hit(idx, BIA_IDX_STATUS);
  assign hit_enable = aligned & idx_hit(idx, BIA_IDX_ENABLE);

  // Source registers live elsewhere; their reads are only snooped here
  assign src_hit[0] = aligned & idx_hit(idx, BIA_IDX_FRAMER);
  assign src_hit[1] = aligned & idx_hit(idx, BIA_IDX_ALARM0);
  assign src_hit[2] = aligned & idx_hit(idx, BIA_IDX_ALARM1);
  assign src_hit[3] = aligned & idx_hit(idx, BIA_IDX_ALARM2);
  assign src_hit[4] = aligned & idx_hit(idx, BIA_IDX_SLIP);
  assign src_hit[5] = aligned & idx_hit(idx, BIA_IDX_HDLC0);
  assign src_hit[6] = aligned & idx_hit(idx, BIA_IDX_HDLC1);
  assign src_hit[7] = aligned & idx_hit(idx, BIA_IDX_HDLC2);
  assign src_hit[8] = aligned & idx_hit(idx, BIA_IDX_LOOP);

  assign mapped = hit_status | hit_enable | (|src_hit);

  ////////////////////////////////////////////////////////////////////////////
  // Bus phases

  logic setup;
  logic commit;
  logic rd_commit;
  logic wr_commit;

  assign setup     = psel & ~penable;
  assign commit    = psel & penable & pready;
  assign rd_commit = commit & ~pwrite;
  assign wr_commit = commit & pwrite;

  ////////////////////////////////////////////////////////////////////////////
  // Enable register

  logic [BIA_REG_W-1:0] block_enable;
  logic [BIA_REG_W-1:0] next_enable;
  logic                 en_write;

  // Only byte lane 0 carries the register
  assign en_write    = wr_commit & hit_enable & ~pslverr & pstrb[0];
  assign next_enable = en_write ? (pwdata[BIA_REG_W-1:0] & BIA_ENABLE_MASK) : block_enable;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      block_enable <= BIA_ENABLE_RST;
    end else begin
      block_enable <= next_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pending flags

  logic [BIA_NFLAG-1:0] flag_set;
  logic [BIA_NFLAG-1:0] flag_clr;
  logic [BIA_NFLAG-1:0] flags;
  logic [BIA_NSRC-1:0]  src_clr;
  logic                 rd_status;
  logic                 alarm_read;
  logic                 hdlc_read;

  // A request only counts when its own source enable is set
  assign flag_set[BIA_NSRC-1:0] = src_req & src_enable;
  assign flag_set[BIA_F_SEC]    = evt_pulse.second_tick;
  assign flag_set[BIA_F_CLK]    = evt_pulse.clk_loss;

  // Source read clears the matching source flag
  assign src_clr = src_hit & {BIA_NSRC{rd_commit & ~pslverr}};
  assign flag_clr[BIA_NSRC-1:0] = src_clr;
  assign alarm_read = |src_clr[3:1];
  assign hdlc_read  = |src_clr[7:5];

  // Clear only what the host actually saw, so an event landing between
  // setup and access is kept for the next read
  assign rd_status           = rd_commit & hit_status & ~pslverr;
  assign flag_clr[BIA_F_SEC] = rd_status & prdata[BIA_BIT_SEC];
  assign flag_clr[BIA_F_CLK] = rd_status & prdata[BIA_BIT_CLK];

  bia_flags #(
    .WIDTH (BIA_NFLAG)
  ) u_flags (
    .pclk    (pclk),
    .presetn (presetn),
    .set     (flag_set),
    .clr     (flag_clr),
    .flags   (flags)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Block status view

  bia_src_t             src_flags;
  logic [BIA_REG_W-1:0] status_now;

  assign src_flags = bia_src_t'(flags[BIA_NSRC-1:0]);

  assign status_now[BIA_BIT_FRAMER] = src_flags.framer;
  assign status_now[BIA_BIT_ALARM]  = |src_flags.alarm;
  assign status_now[BIA_BIT_SLIP]   = src_flags.slip;
  assign status_now[BIA_BIT_HDLC]   = |src_flags.hdlc;
  assign status_now[BIA_BIT_SEC]    = flags[BIA_F_SEC];
  assign status_now[BIA_BIT_CLK]    = flags[BIA_F_CLK];
  assign status_now[BIA_BIT_LOOP]   = src_flags.loop;
  assign status_now[BIA_REG_W-1]    = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt

  logic [BIA_REG_W-1:0] gated;
  logic                 next_irq;

  // Bits 6 and 3 gate whole blocks, bits 5 and 4 single sources
  assign gated    = status_now & block_enable;
  assign next_irq = |gated;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB answer: ready in the first access cycle, no wait states

  logic [BIA_DATA_W-1:0] rd_value;
  logic [BIA_DATA_W-1:0] next_prdata;

  assign rd_value = hit_status ? BIA_DATA_W'(status_now) :
                    hit_enable ? BIA_DATA_W'(block_enable) : '0;

  assign next_prdata = (setup & ~pwrite) ? rd_value :
                       commit            ? '0       : prdata;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= next_prdata;
      pready  <= setup;
      pslverr <= setup & ~mapped;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  slip_set_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    src_req.slip && src_enable.slip |=> status_now[BIA_BIT_SLIP]
  ) else $error("slip status bit missed a request");

  slip_clear_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    src_clr[4] && !(src_req.slip && src_enable.slip)
      |=> !status_now[BIA_BIT_SLIP]
  ) else $error("slip status bit not cleared by source read");

  alarm_set_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    |(src_req.alarm & src_enable.alarm) |=> status_now[BIA_BIT_ALARM]
  ) else $error("alarm status bit missed a request");

  alarm_clear_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    $fell(status_now[BIA_BIT_ALARM]) |-> $past(alarm_read)
  ) else $error("alarm status bit fell without a source read");

  framer_set_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    src_req.framer && src_enable.framer |=> status_now[BIA_BIT_FRAMER]
  ) else $error("framer status bit missed a request");

  framer_clear_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    src_clr[0] && !(src_req.framer && src_enable.framer)
      |=> !status_now[BIA_BIT_FRAMER]
  ) else $error("framer status bit not cleared by source read");

  loop_gate_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    $onehot(status_now) && status_now[BIA_BIT_LOOP] && !block_enable[BIA_BIT_LOOP]
      |=> !irq
  ) else $error("loop code request passed a cleared block enable");

  source_gate_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    src_req.framer && !src_enable.framer && !status_now[BIA_BIT_FRAMER]
      |=> !status_now[BIA_BIT_FRAMER]
  ) else $error("framer request passed a cleared source enable");

  clk_gate_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    status_now[BIA_BIT_CLK] && block_enable[BIA_BIT_CLK] |=> irq
  ) else $error("enabled clock loss did not raise the interrupt");

  sec_gate_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    status_now[BIA_BIT_SEC] && block_enable[BIA_BIT_SEC] |=> irq
  ) else $error("enabled one second tick did not raise the interrupt");

  hdlc_gate_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    status_now[BIA_BIT_HDLC] && block_enable[BIA_BIT_HDLC] |=> irq
  ) else $error("enabled link controller block did not raise the interrupt");

  loop_flag_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    src_req.loop && src_enable.loop |=> status_now[BIA_BIT_LOOP]
  ) else $error("loop code status bit missed a request");

  clk_sticky_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    evt_pulse.clk_loss ##1 !rd_status [*2] |-> status_now[BIA_BIT_CLK]
  ) else $error("clock loss status bit did not hold until read");

  sec_read_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    rd_status && prdata[BIA_BIT_SEC] && !evt_pulse.second_tick
      |=> !status_now[BIA_BIT_SEC]
  ) else $error("one second status bit not cleared by status read");

  hdlc_clear_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    $fell(status_now[BIA_BIT_HDLC]) |-> $past(hdlc_read)
  ) else $error("link controller status bit fell without a source read");

  irq_or_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    block_enable == '0 ##1 block_enable == '0 |-> !irq
  ) else $error("interrupt raised with every enable bit clear");

  irq_idle_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    status_now == '0 |=> !irq
  ) else $error("interrupt raised with no status bit pending");

  alarm_src_clear_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    src_clr[1] && !(src_req.alarm[0] && src_enable.alarm[0])
      |=> !src_flags.alarm[0]
  ) else $error("alarm flag not cleared by its source read");

  loop_clear_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    src_clr[8] && !(src_req.loop && src_enable.loop)
      |=> !status_now[BIA_BIT_LOOP]
  ) else $error("loop code status bit not cleared by source read");

  hdlc_set_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    |(src_req.hdlc & src_enable.hdlc) |=> status_now[BIA_BIT_HDLC]
  ) else $error("link controller status bit missed a request");

  hdlc_block_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    $onehot(status_now) && status_now[BIA_BIT_HDLC] && !block_enable[BIA_BIT_HDLC]
      |=> !irq
  ) else $error("link controller request passed a cleared block enable");

  clk_read_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    rd_status && prdata[BIA_BIT_CLK] && !evt_pulse.clk_loss
      |=> !status_now[BIA_BIT_CLK]
  ) else $error("clock loss status bit not cleared by status read");

  sec_sticky_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    evt_pulse.second_tick ##1 !rd_status [*2] |-> status_now[BIA_BIT_SEC]
  ) else $error("one second status bit did not hold until read");

  // Bus answer: ready follows every setup cycle, error only off the map
  ready_answer_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    setup |=> pready
  ) else $error("setup cycle not answered in the first access cycle");

  unmapped_err_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && !mapped |=> pslverr
  ) else $error("unmapped access answered without an error");

endmodule // bia_top

//--- test/bia_tb_top.sv
`timescale 1ns/1ps
module bia_tb_top;
  import bia_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Stimulus tables and design wiring
  localparam logic [3:0]  CH = 4'h3;
  localparam logic [11:0] SIDX [9] = '{BIA_IDX_FRAMER, BIA_IDX_ALARM0, BIA_IDX_ALARM1,
    BIA_IDX_ALARM2, BIA_IDX_SLIP, BIA_IDX_HDLC0, BIA_IDX_HDLC1, BIA_IDX_HDLC2, BIA_IDX_LOOP};
  // Status bit of each source; 9 and 10 are the second tick and clock loss strobes
  localparam int          SBLK [11] = '{0, 1, 1, 1, 2, 3, 3, 3, 6, 4, 5};
  localparam int          BSRC [7]  = '{0, 1, 4, 5, 9, 10, 8};

  logic                  pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [BIA_ADDR_W-1:0] paddr;
  logic [BIA_DATA_W-1:0] pwdata, prdata;
  logic [3:0]            pstrb;
  bia_src_t              src_req, src_enable;
  bia_evt_t              evt_pulse;
  int                    failures, checks_done;

  bia_top #(.CHANNEL(CH)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .src_req(src_req), .src_enable(src_enable),
    .evt_pulse(evt_pulse), .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Holds the request until pready is seen high; the wait is then judged
  // against the one-cycle answer, and only the watchdog cuts a hang short
  task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd,
                     input logic [3:0] st, output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {CH, idx, BIA_ALIGNED};
    pwdata  <= wd;
    pstrb   <= st;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    chk("pready wait", 32'h0000_0001, n);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] idx, input logic [31:0] exp, input string what);
    logic [31:0] d;
    logic        e;
    apb(1'b0, idx, 32'h0000_0000, 4'hF, d, e);
    chk(what, exp, d);
    chk("pslverr", 32'h0000_0000, {31'h0, e});
  endtask

  task automatic wr(input logic [11:0] idx, input logic [31:0] wd, input logic [3:0] st);
    logic [31:0] d;
    logic        e;
    apb(1'b1, idx, wd, st, d, e);
  endtask

  // irq is registered behind the flags, so allow a few edges to settle
  task automatic irq_chk(input logic exp);
    repeat (3) @(posedge pclk);
    chk("irq", {31'h0, exp}, {31'h0, irq});
  endtask

  task automatic pulse(input int s);
    @(posedge pclk);
    if (s < 9) begin
      src_req <= bia_src_t'(9'h001 << s);
    end else begin
      evt_pulse <= bia_evt_t'(2'h1 << (s - 9));
    end
    @(posedge pclk);
    src_req   <= '0;
    evt_pulse <= '0;
    repeat (2) @(posedge pclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    rd_chk(BIA_IDX_STATUS, 32'h0000_0000, "status reset");
    rd_chk(BIA_IDX_ENABLE, {24'h0, BIA_ENABLE_RST}, "enable reset");
    irq_chk(1'b0);
  endtask

  task automatic t_sources();
    wr(BIA_IDX_ENABLE, 32'h0000_007F, 4'hF);
    for (int s = 0; s < 11; s++) begin
      pulse(s);
      irq_chk(1'b1);
      rd_chk(BIA_IDX_STATUS, 32'h1 << SBLK[s], "status set");
      if (s < 9) begin
        rd_chk(SIDX[s], 32'h0000_0000, "source read");
      end
      rd_chk(BIA_IDX_STATUS, 32'h0000_0000, "status clear");
      irq_chk(1'b0);
    end
  endtask

  task automatic t_gating();
    int s;
    for (int b = 0; b < 7; b++) begin
      s = BSRC[b];
      wr(BIA_IDX_ENABLE, 32'h0000_007F & ~(32'h1 << b), 4'hF);
      pulse(s);
      irq_chk(1'b0);
      wr(BIA_IDX_ENABLE, 32'h1 << b, 4'hF);
      irq_chk(1'b1);
      if (s < 9) begin
        rd_chk(SIDX[s], 32'h0000_0000, "source read");
      end
      rd_chk(BIA_IDX_STATUS, (s < 9) ? 32'h0 : 32'h1 << b, "status");
      irq_chk(1'b0);
    end
  endtask

  task automatic t_src_enable();
    wr(BIA_IDX_ENABLE, 32'h0000_007F, 4'hF);
    @(posedge pclk);
    src_enable <= '0;
    pulse(0);
    pulse(4);
    rd_chk(BIA_IDX_STATUS, 32'h0000_0000, "masked source");
    irq_chk(1'b0);
    @(posedge pclk);
    src_enable <= '1;
  endtask

  // Refused accesses must leave both registers untouched
  task automatic t_refuse();
    logic [31:0] d;
    logic        e;
    apb(1'b0, 12'hB03, 32'h0000_0000, 4'hF, d, e);
    chk("unmapped err", 32'h0000_0001, {31'h0, e});
    chk("unmapped data", 32'h0000_0000, d);
    wr(BIA_IDX_STATUS, 32'h0000_00FF, 4'hF);
    rd_chk(BIA_IDX_STATUS, 32'h0000_0000, "status read only");
    wr(BIA_IDX_ENABLE, 32'h0000_00FF, 4'hF);
    rd_chk(BIA_IDX_ENABLE, {24'h0, BIA_ENABLE_MASK}, "enable bit7");
    wr(BIA_IDX_ENABLE, 32'h0000_0000, 4'h0);
    wr(12'hB03, 32'h0000_0000, 4'hF);
    rd_chk(BIA_IDX_ENABLE, {24'h0, BIA_ENABLE_MASK}, "enable kept");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Run control
  task automatic wrap_up();
    $display("checks_done=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // Whole run needs under 500 cycles; this only cuts a hang short
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    wrap_up();
  end

  initial begin
    presetn     = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = '0;
    pwdata      = '0;
    pstrb       = 4'h0;
    src_req     = '0;
    src_enable  = '1;
    evt_pulse   = '0;
    failures    = 0;
    checks_done = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_sources();
    t_gating();
    t_src_enable();
    t_refuse();
    wrap_up();
  end

endmodule // bia_tb_top
